/* File: sbc_pkg.sv */
// constants and types shared by the serial control port of the basis chip
package sbc_pkg;

  // ----------------------------------------------------------------
  // command word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_W = 7;
  localparam int WR_BIT = 7;
  localparam int DATA_LSB = 8;
  localparam int DATA_W = 8;
  localparam logic [4:0] FRAME_EDGES = 5'h10;
  localparam logic [4:0] CNT_MAX = 5'h1F;
  localparam logic [15:0] WORD_ZEROS = 16'h0000;
  localparam logic [15:0] WORD_ONES = 16'hFFFF;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] ADR_MODE_CTRL = 7'h01;
  localparam logic [6:0] ADR_WATCHDOG_CONTROL_REG = 7'h02;
  localparam logic [6:0] ADR_SUPPLY_CTRL = 7'h03;
  localparam logic [6:0] ADR_BUS_WAKE = 7'h04;
  localparam logic [6:0] ADR_WAKE_SRC = 7'h05;
  localparam logic [6:0] ADR_TIMER = 7'h06;
  localparam logic [6:0] ADR_DEV_STAT = 7'h43;
  localparam logic [6:0] ADR_WAKE_STAT1 = 7'h46;
  localparam logic [6:0] ADR_WAKE_STAT2 = 7'h47;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MODE_REQ_LSB = 6;
  localparam int LS_BIT = 0;
  localparam int MEAS_BIT = 7;
  localparam int WK1_BIT = 0;
  localparam int WK2_BIT = 1;
  localparam int TMR_ON_LSB = 4;
  localparam int FAULT_BIT = 0;

  // mode request codes in the mode control byte
  localparam logic [1:0] REQ_NORMAL = 2'h0;
  localparam logic [1:0] REQ_SLEEP = 2'h1;
  localparam logic [1:0] REQ_STOP = 2'h2;
  localparam logic [1:0] REQ_SOFT_RESET = 2'h3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_WATCHDOG_CONTROL_REG = 8'h00;
  localparam logic [5:0] RST_MODE_SET = 6'h00;
  localparam logic [7:0] RST_BUS_WAKE = 8'h00;
  localparam logic [7:0] RST_WAKE_SRC = 8'h00;
  localparam logic [3:0] RST_TMR = 4'h0;
  localparam logic [15:0] RST_RESP = 16'h0000;

  typedef enum logic [2:0] {
    SBC_INIT,
    SBC_NORMAL,
    SBC_STOP,
    SBC_SLEEP,
    SBC_RESTART
  } sbc_mode_t;

endpackage : sbc_pkg

/* File: sbc_spi_slave_checker.sv */
// serial control port with command checking against the chip mode machine
`timescale 1ns/1ps

// Notes on behaviour
// [RQ1] each frame carries a 16-bit command in and a response word out
// [RQ2] frame opens on select low; the word is acted on only after select rises
// [RQ3] data output goes high impedance when select rises
// [RQ4] input bit captured on every falling serial clock edge
// [RQ5] next output bit presented after every rising serial clock edge
// [RQ6] illegal write ignored, sticky fault set, cleared only by explicit command
// [RQ7] stop to sleep request: fault and restart mode
// [RQ8] stop or sleep request from init: fault and normal mode
// [RQ9] watchdog byte with uneven parity: fault, trigger and settings discarded
// [RQ10] in stop only trigger, normal, soft reset, status clears are accepted
// [RQ11] stop entry with wake status pending: no fault, interrupt pulse
// [RQ12] stop to normal with other mode bits changed: mode only, fault
// [RQ13] sleep with all wake sources clear: fault, restart, rest still executes
// [RQ14] clearing enabled load sharing keeps it set, rest executes, fault
// [RQ15] sleep with measurement and only wake input one or two: fault, restart
// [RQ16] timer on-time not below its period: fault, rejected
// [RQ17] all-zero or all-one word is a fault
// [RQ18] unused addresses never raise the fault
// [RQ19] edge count other than 0 or 16 discards the word, sets frame error
// [RQ20] clock high at select edges is a frame error, shown first bit next frame
// [RQ21] frame during low reset output sets the frame error
// [RQ22] master keeps clock low at select fall for a valid error bit
// [RQ23] bits 6..0 address, bit 7 write or clear, bits 15..8 data
// [RQ24] output held high for the whole frame while reset output is low
module sbc_spi_slave_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic spi_clk,
  input wire logic chip_select_low,
  input wire logic serial_in_line,
  output logic serial_out_line,
  output logic serial_out_line_oe,
  input wire logic reset_output_pin,
  input wire logic restart_done,
  input wire logic wake_event,
  input wire logic [7:0] wake_status_first_set,
  input wire logic [7:0] wake_status_second_set,
  output sbc_pkg::sbc_mode_t mode_state,
  output logic cmd_fault_flag,
  output logic frame_err_flag,
  output logic int_pulse,
  output logic wd_trigger,
  output logic [7:0] watchdog_control_reg,
  output logic [5:0] mode_settings,
  output logic aux_load_sharing,
  output logic [7:0] bus_wake_control,
  output logic [7:0] wake_source_control,
  output logic [3:0] timer_period,
  output logic [3:0] timer_on_time,
  output logic [7:0] wake_status_first,
  output logic [7:0] wake_status_second
);
  import sbc_pkg::*;

  // ----------------------------------------------------------------
  // select-edge domain
  // ----------------------------------------------------------------
  // the serial clock stops between frames, so frame start is marked by a
  // toggle clocked on the select fall itself; clock level is caught at both
  // select edges for the frame error check
  logic start_tog_r;
  logic clk_hi_start_r;
  logic clk_hi_end_r;

  always_ff @(posedge chip_select_low or negedge rst_n) begin
    if (!rst_n) begin
      clk_hi_end_r <= 1'b0;
    end else begin
      clk_hi_end_r <= spi_clk; // RQ20
    end
  end

  // ----------------------------------------------------------------
  // link receive side, falling serial clock
  // ----------------------------------------------------------------
  typedef struct packed {
    logic in_seen;
    logic [4:0] cnt;
    logic [15:0] word;
  } sbc_rx_t;

  sbc_rx_t rx_r;
  sbc_rx_t rx_nxt;

  always_comb begin
    rx_nxt = rx_r;
    if (rx_r.in_seen != start_tog_r) begin
      // first edge of a new frame restarts the count
      rx_nxt.in_seen = start_tog_r;
      rx_nxt.cnt = 5'h01; // RQ19
      rx_nxt.word = {serial_in_line, 15'h0000}; // RQ4
    end else begin
      if (rx_r.cnt != CNT_MAX) begin
        rx_nxt.cnt = rx_r.cnt + 5'h01; // RQ19
      end
      rx_nxt.word = {serial_in_line, rx_r.word[15:1]}; // RQ4 RQ1
    end
  end

  always_ff @(negedge spi_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_r <= '0;
    end else begin
      rx_r <= rx_nxt;
    end
  end

  always_ff @(negedge chip_select_low or negedge rst_n) begin
    if (!rst_n) begin
      start_tog_r <= 1'b0;
      clk_hi_start_r <= 1'b0;
    end else begin
      start_tog_r <= ~rx_r.in_seen;
      clk_hi_start_r <= spi_clk; // RQ20
    end
  end

  // ----------------------------------------------------------------
  // link transmit side, rising serial clock
  // ----------------------------------------------------------------
  typedef struct packed {
    logic out_seen;
    logic [14:0] out_sr;
  } sbc_tx_t;

  sbc_tx_t tx_r;
  sbc_tx_t tx_nxt;
  logic [15:0] resp_word;

  always_comb begin
    tx_nxt = tx_r;
    if (tx_r.out_seen != start_tog_r) begin
      // first rising edge: bit 0 already stood on the line
      tx_nxt.out_seen = start_tog_r;
      tx_nxt.out_sr = resp_word[15:1]; // RQ5
    end else begin
      tx_nxt.out_sr = {1'b0, tx_r.out_sr[14:1]}; // RQ5
    end
  end

  always_ff @(posedge spi_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_r <= '0;
    end else begin
      tx_r <= tx_nxt;
    end
  end

  // ----------------------------------------------------------------
  // reference clock domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_d;
    logic ro_s1;
    logic ro_s2;
    logic rd_s1;
    logic rd_s2;
    logic wk_s1;
    logic wk_s2;
    logic [7:0] ws1_s1;
    logic [7:0] ws1_s2;
    logic [7:0] ws2_s1;
    logic [7:0] ws2_s2;
    logic ro_low_seen;
    sbc_mode_t mode;
    logic err;
    logic fault;
    logic irq;
    logic wdt;
    logic [7:0] wd_reg;
    logic [5:0] mode_set;
    logic ls;
    logic [7:0] bus_wc;
    logic [7:0] wake_sc;
    logic [3:0] tper;
    logic [3:0] ton;
    logic [7:0] wstat1;
    logic [7:0] wstat2;
    logic [7:0] rd_data;
    logic [15:0] resp;
  } sbc_ref_t;

  sbc_ref_t r_r;
  sbc_ref_t r_nxt;

  // uneven parity of a data byte
  function automatic logic odd_parity(input logic [7:0] d);
    odd_parity = ^d;
  endfunction : odd_parity

  always_comb begin
    logic [4:0] cnt_eff;
    logic bad_frame;
    logic [15:0] w;
    logic [6:0] adr;
    logic wr;
    logic [7:0] d;
    logic [1:0] req;
    logic [5:0] oth;
    logic fault_set;
    logic fault_clr;
    logic [7:0] ws1_clr;
    logic [7:0] ws2_clr;
    logic no_wake;
    logic meas_only_12;
    cnt_eff = 5'h00;
    bad_frame = 1'b0;
    w = rx_r.word;
    adr = w[ADDR_LSB +: ADDR_W]; // RQ23
    wr = w[WR_BIT]; // RQ23
    d = w[DATA_LSB +: DATA_W]; // RQ23
    req = d[MODE_REQ_LSB +: 2];
    oth = d[5:0];
    fault_set = 1'b0;
    fault_clr = 1'b0;
    ws1_clr = 8'h00;
    ws2_clr = 8'h00;
    no_wake = (r_r.bus_wc == 8'h00) && (r_r.wake_sc == 8'h00);
    meas_only_12 = r_r.wake_sc[MEAS_BIT] && (r_r.bus_wc == 8'h00)
      && (r_r.wake_sc[6:2] == 5'h00)
      && (r_r.wake_sc[WK1_BIT] || r_r.wake_sc[WK2_BIT]);

    r_nxt = r_r;
    r_nxt.irq = 1'b0;
    r_nxt.wdt = 1'b0;
    r_nxt.cs_s1 = chip_select_low;
    r_nxt.cs_s2 = r_r.cs_s1;
    r_nxt.cs_d = r_r.cs_s2;
    r_nxt.ro_s1 = reset_output_pin;
    r_nxt.ro_s2 = r_r.ro_s1;
    r_nxt.rd_s1 = restart_done;
    r_nxt.rd_s2 = r_r.rd_s1;
    r_nxt.wk_s1 = wake_event;
    r_nxt.wk_s2 = r_r.wk_s1;
    r_nxt.ws1_s1 = wake_status_first_set;
    r_nxt.ws1_s2 = r_r.ws1_s1;
    r_nxt.ws2_s1 = wake_status_second_set;
    r_nxt.ws2_s2 = r_r.ws2_s1;

    // frame overlapping a low reset output counts as a frame error
    if (!r_r.cs_s2 && !r_r.ro_s2) begin
      r_nxt.ro_low_seen = 1'b1; // RQ21
    end

    // mode machine steps that do not come from a command
    if (r_r.mode == SBC_SLEEP && r_r.wk_s2) begin
      r_nxt.mode = SBC_RESTART;
    end
    if (r_r.mode == SBC_RESTART && r_r.rd_s2) begin
      r_nxt.mode = SBC_NORMAL;
    end

    // word is acted on only once select is back high; link registers are
    // quiet by then because the serial clock has stopped
    if (r_r.cs_s2 && !r_r.cs_d) begin // RQ2
      cnt_eff = (rx_r.in_seen == start_tog_r) ? rx_r.cnt : 5'h00;
      bad_frame = ((cnt_eff != 5'h00) && (cnt_eff != FRAME_EDGES)) // RQ19
        || clk_hi_start_r || clk_hi_end_r // RQ20
        || r_r.ro_low_seen || !r_r.ro_s2; // RQ21
      r_nxt.err = bad_frame; // RQ20
      r_nxt.ro_low_seen = 1'b0;
      // commands are not interpreted while restarting
      if (!bad_frame && cnt_eff == FRAME_EDGES && r_r.mode != SBC_RESTART) begin
        if (w == WORD_ZEROS || w == WORD_ONES) begin
          fault_set = 1'b1; // RQ17
        end else begin
          case (adr)
            ADR_MODE_CTRL: begin
              r_nxt.rd_data = {2'h0, r_r.mode_set};
              if (wr) begin
                case (r_r.mode)
                  SBC_STOP: begin
                    if (req == REQ_NORMAL) begin
                      r_nxt.mode = SBC_NORMAL;
                      fault_set = (oth != r_r.mode_set); // RQ12
                    end else if (req == REQ_SOFT_RESET) begin
                      r_nxt.mode = SBC_RESTART; // RQ10
                    end else if (req == REQ_SLEEP) begin
                      fault_set = 1'b1; // RQ7
                      r_nxt.mode = SBC_RESTART; // RQ7
                    end else begin
                      fault_set = (oth != r_r.mode_set); // RQ10
                    end
                  end
                  SBC_INIT: begin
                    r_nxt.mode_set = oth;
                    if (req == REQ_STOP || req == REQ_SLEEP) begin
                      fault_set = 1'b1; // RQ8
                      r_nxt.mode = SBC_NORMAL; // RQ8
                    end else if (req == REQ_SOFT_RESET) begin
                      r_nxt.mode = SBC_RESTART;
                    end else begin
                      r_nxt.mode = SBC_NORMAL;
                    end
                  end
                  default: begin
                    r_nxt.mode_set = oth;
                    case (req)
                      REQ_STOP: begin
                        r_nxt.mode = SBC_STOP;
                        // pending wake status: interrupt, fault untouched
                        r_nxt.irq = (r_r.wstat1 != 8'h00) || (r_r.wstat2 != 8'h00); // RQ11
                      end
                      REQ_SLEEP: begin
                        if (no_wake || meas_only_12) begin
                          fault_set = 1'b1; // RQ13 RQ15
                          r_nxt.mode = SBC_RESTART; // RQ13 RQ15
                        end else begin
                          r_nxt.mode = SBC_SLEEP;
                        end
                      end
                      REQ_SOFT_RESET: r_nxt.mode = SBC_RESTART;
                      default: r_nxt.mode = SBC_NORMAL;
                    endcase
                  end
                endcase
              end
            end
            ADR_WATCHDOG_CONTROL_REG: begin
              r_nxt.rd_data = r_r.wd_reg;
              if (wr) begin
                if (odd_parity(d)) begin
                  fault_set = 1'b1; // RQ9
                end else begin
                  r_nxt.wd_reg = d;
                  r_nxt.wdt = 1'b1;
                end
              end
            end
            ADR_SUPPLY_CTRL: begin
              r_nxt.rd_data = {7'h00, r_r.ls};
              if (wr) begin
                if (r_r.mode == SBC_STOP) begin
                  fault_set = 1'b1; // RQ10
                end else if (r_r.ls && !d[LS_BIT]) begin
                  fault_set = 1'b1; // RQ14
                end else begin
                  r_nxt.ls = d[LS_BIT];
                end
              end
            end
            ADR_BUS_WAKE: begin
              r_nxt.rd_data = r_r.bus_wc;
              if (wr) begin
                if (r_r.mode == SBC_STOP) begin
                  fault_set = 1'b1; // RQ10
                end else begin
                  r_nxt.bus_wc = d;
                end
              end
            end
            ADR_WAKE_SRC: begin
              r_nxt.rd_data = r_r.wake_sc;
              if (wr) begin
                if (r_r.mode == SBC_STOP) begin
                  fault_set = 1'b1; // RQ10
                end else begin
                  r_nxt.wake_sc = d;
                end
              end
            end
            ADR_TIMER: begin
              r_nxt.rd_data = {r_r.ton, r_r.tper};
              if (wr) begin
                if (r_r.mode == SBC_STOP) begin
                  fault_set = 1'b1; // RQ10
                end else if (d[TMR_ON_LSB +: 4] >= d[3:0]) begin
                  fault_set = 1'b1; // RQ16
                end else begin
                  r_nxt.tper = d[3:0];
                  r_nxt.ton = d[TMR_ON_LSB +: 4];
                end
              end
            end
            ADR_DEV_STAT: begin
              r_nxt.rd_data = {7'h00, r_r.fault};
              fault_clr = wr; // RQ6
            end
            ADR_WAKE_STAT1: begin
              r_nxt.rd_data = r_r.wstat1;
              ws1_clr = wr ? 8'hFF : 8'h00;
            end
            ADR_WAKE_STAT2: begin
              r_nxt.rd_data = r_r.wstat2;
              ws2_clr = wr ? 8'hFF : 8'h00;
            end
            default: begin
              r_nxt.rd_data = 8'h00; // RQ18
            end
          endcase
        end
      end
    end

    // sticky flags: a set in the clearing cycle wins
    r_nxt.fault = (r_r.fault & ~fault_clr) | fault_set; // RQ6
    r_nxt.wstat1 = (r_r.wstat1 & ~ws1_clr) | r_r.ws1_s2;
    r_nxt.wstat2 = (r_r.wstat2 & ~ws2_clr) | r_r.ws2_s2;

    // response frozen between frame ends so the link sees a stable word
    if (r_r.cs_s2 && !r_r.cs_d) begin
      r_nxt.resp = {r_nxt.rd_data, 2'h0,
        (r_nxt.wstat1 != 8'h00) || (r_nxt.wstat2 != 8'h00),
        r_nxt.mode, r_nxt.fault, r_nxt.err}; // RQ20
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '{
        cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1,
        ro_s1: 1'b1, ro_s2: 1'b1,
        rd_s1: 1'b0, rd_s2: 1'b0, wk_s1: 1'b0, wk_s2: 1'b0,
        ws1_s1: 8'h00, ws1_s2: 8'h00, ws2_s1: 8'h00, ws2_s2: 8'h00,
        ro_low_seen: 1'b0, mode: SBC_INIT, err: 1'b0, fault: 1'b0,
        irq: 1'b0, wdt: 1'b0, wd_reg: RST_WATCHDOG_CONTROL_REG, mode_set: RST_MODE_SET,
        ls: 1'b0, bus_wc: RST_BUS_WAKE, wake_sc: RST_WAKE_SRC,
        tper: RST_TMR, ton: RST_TMR, wstat1: 8'h00, wstat2: 8'h00,
        rd_data: 8'h00, resp: RST_RESP
      };
    end else begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pins and outputs
  // ----------------------------------------------------------------
  assign resp_word = r_r.resp;
  // line released as soon as select rises, no clock needed
  assign serial_out_line_oe = ~chip_select_low; // RQ3
  // error bit stands before the first rising edge of the next frame
  assign serial_out_line = !r_r.ro_s2 ? 1'b1 // RQ24
    : (tx_r.out_seen != start_tog_r) ? resp_word[0] : tx_r.out_sr[0]; // RQ20 RQ5
  assign mode_state = r_r.mode;
  assign cmd_fault_flag = r_r.fault;
  assign frame_err_flag = r_r.err;
  assign int_pulse = r_r.irq;
  assign wd_trigger = r_r.wdt;
  assign watchdog_control_reg = r_r.wd_reg;
  assign mode_settings = r_r.mode_set;
  assign aux_load_sharing = r_r.ls;
  assign bus_wake_control = r_r.bus_wc;
  assign wake_source_control = r_r.wake_sc;
  assign timer_period = r_r.tper;
  assign timer_on_time = r_r.ton;
  assign wake_status_first = r_r.wstat1;
  assign wake_status_second = r_r.wstat2;

endmodule : sbc_spi_slave_checker

/* File: sbc_spi_master.sv */
// serial master model that frames command words toward the control port
`timescale 1ns/1ps
module sbc_spi_master (
  input wire logic ref_clk,
  input wire logic serial_out_line,
  output logic spi_clk,
  output logic chip_select_low,
  output logic serial_in_line
);
  // ----------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------
  localparam int HALF = 40;
  initial begin
    spi_clk = 1'b0;
    chip_select_low = 1'b1;
    serial_in_line = 1'b0;
  end
  // edge counts other than 0 or 16, or clk_hi, give a deliberately broken frame
  task automatic xfer(input logic [15:0] word, input int n, input bit clk_hi,
                      output logic [15:0] resp);
    resp = 16'h0000;
    @(negedge ref_clk);
    spi_clk = clk_hi;
    chip_select_low = 1'b0;
    serial_in_line = word[0];
    // odd offset keeps the link clock out of phase with ref_clk
    #53;
    resp[0] = serial_out_line;
    for (int i = 0; i < n; i++) begin
      spi_clk = 1'b1;
      serial_in_line = word[i % 16];
      #HALF;
      if (i < 15) resp[i + 1] = serial_out_line;
      spi_clk = 1'b0;
      #HALF;
    end
    @(negedge ref_clk);
    spi_clk = clk_hi;
    chip_select_low = 1'b1;
    @(negedge ref_clk);
    spi_clk = 1'b0;
    // released data line must not keep showing the last bit
    serial_in_line = ~serial_in_line;
    repeat (8) @(negedge ref_clk);
  endtask : xfer
endmodule : sbc_spi_master

/* File: sbc_port_checker.sv */
// concurrent checks on the serial control port pins
`timescale 1ns/1ps
module sbc_port_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic chip_select_low,
  input wire logic serial_out_line,
  input wire logic serial_out_line_oe,
  input wire logic reset_output_pin,
  input sbc_pkg::sbc_mode_t mode_state,
  input wire logic cmd_fault_flag,
  input wire logic frame_err_flag,
  input wire logic int_pulse,
  input wire logic wd_trigger,
  input wire logic [7:0] watchdog_control_reg,
  input wire logic [3:0] timer_period,
  input wire logic [3:0] timer_on_time
);
  import sbc_pkg::*;
  // ----------------------------------------------------------------
  // pin relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  select_enable_a: assert property (serial_out_line_oe == !chip_select_low)
    else $error("output enable does not follow select");
  fault_after_frame_a: assert property ($changed(cmd_fault_flag)
    |-> chip_select_low && $past(chip_select_low, 2)) else $error("fault moved in frame");
  err_after_frame_a: assert property ($changed(frame_err_flag)
    |-> chip_select_low && $past(chip_select_low, 2)) else $error("error moved in frame");
  config_after_frame_a: assert property ($changed(watchdog_control_reg)
    |-> chip_select_low && $past(chip_select_low, 2)) else $error("config moved in frame");
  int_in_stop_a: assert property (int_pulse
    |-> mode_state == SBC_STOP && !$changed(cmd_fault_flag) ##1 !int_pulse)
    else $error("interrupt pulse wrong");
  wd_clean_a: assert property (wd_trigger |-> !$changed(cmd_fault_flag) ##1 !wd_trigger)
    else $error("trigger pulse wrong");
  out_high_rst_a: assert property (!reset_output_pin [*4] |-> serial_out_line)
    else $error("output not high in reset");
  timer_order_a: assert property ($changed(timer_on_time) || $changed(timer_period)
    |-> timer_on_time < timer_period || (timer_on_time == 4'h0 && timer_period == 4'h0))
    else $error("timer on-time not below period");
endmodule : sbc_port_checker

bind sbc_spi_slave_checker sbc_port_checker sbc_port_checker_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .chip_select_low(chip_select_low),
  .serial_out_line(serial_out_line), .serial_out_line_oe(serial_out_line_oe),
  .reset_output_pin(reset_output_pin), .mode_state(mode_state),
  .cmd_fault_flag(cmd_fault_flag), .frame_err_flag(frame_err_flag), .int_pulse(int_pulse),
  .wd_trigger(wd_trigger), .watchdog_control_reg(watchdog_control_reg),
  .timer_period(timer_period), .timer_on_time(timer_on_time));

/* File: sbc_spi_slave_checker_tb_top.sv */
// self-checking bench for the serial control port
`timescale 1ns/1ps
module sbc_spi_slave_checker_tb_top;
  import sbc_pkg::*;
  logic ref_clk, rst_n, spi_clk, chip_select_low, serial_in_line, serial_out_line;
  logic serial_out_line_oe, reset_output_pin, restart_done, cmd_fault_flag, frame_err_flag;
  logic int_pulse, wd_trigger, aux_load_sharing;
  logic [7:0] wake_status_first_set, watchdog_control_reg, wake_status_first;
  logic [5:0] mode_settings;
  logic [3:0] timer_period, timer_on_time;
  logic [15:0] resp;
  sbc_mode_t mode_state;
  int miscompares, n_checks, n_int, n_wd;
  logic [15:0] stuck [2] = '{16'hFFFF, 16'h0000};
  // ----------------------------------------------------------------
  // structure
  // ----------------------------------------------------------------
  sbc_spi_slave_checker sbc_spi_slave_checker_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .spi_clk(spi_clk), .chip_select_low(chip_select_low),
    .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
    .serial_out_line_oe(serial_out_line_oe), .reset_output_pin(reset_output_pin),
    .restart_done(restart_done), .wake_event(1'b0),
    .wake_status_first_set(wake_status_first_set), .wake_status_second_set(8'h00),
    .mode_state(mode_state), .cmd_fault_flag(cmd_fault_flag),
    .frame_err_flag(frame_err_flag), .int_pulse(int_pulse), .wd_trigger(wd_trigger),
    .watchdog_control_reg(watchdog_control_reg), .mode_settings(mode_settings),
    .aux_load_sharing(aux_load_sharing), .bus_wake_control(), .wake_source_control(),
    .timer_period(timer_period), .timer_on_time(timer_on_time),
    .wake_status_first(wake_status_first), .wake_status_second());
  sbc_spi_master sbc_spi_master_inst (
    .ref_clk(ref_clk), .serial_out_line(serial_out_line), .spi_clk(spi_clk),
    .chip_select_low(chip_select_low), .serial_in_line(serial_in_line));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (int_pulse === 1'b1) n_int++;
    if (wd_trigger === 1'b1) n_wd++;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic frame(input logic [15:0] word, input int n = 16, input bit hi = 1'b0);
    sbc_spi_master_inst.xfer(word, n, hi, resp);
  endtask : frame
  task automatic fault(input logic exp);
    chk(16'(cmd_fault_flag), 16'(exp), "fault");
    if (exp) frame(16'h00C3);
  endtask : fault
  task automatic mode(input sbc_mode_t exp);
    chk(16'(mode_state), 16'(exp), "mode");
  endtask : mode
  task automatic leave_restart;
    restart_done = 1'b1;
    repeat (6) @(negedge ref_clk);
    restart_done = 1'b0;
    repeat (6) @(negedge ref_clk);
  endtask : leave_restart
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {miscompares, n_checks, n_int, n_wd} = '0;
    {rst_n, restart_done, reset_output_pin, wake_status_first_set} = 11'h100;
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    frame(16'h0000, 0);
    chk(16'(resp[0]), 16'h0000, "err bit");
    frame(16'h0382);
    chk(16'(watchdog_control_reg), 16'h0003, "wd");
    chk(16'(n_wd), 16'h0001, "wd pulses");
    frame(16'h0002);
    chk(16'(resp[15:8]), 16'h0000, "old data");
    mode(SBC_INIT);
    frame(16'h55A0);
    chk({resp[15:8], 3'h0, resp[4:0]}, {8'h03, 3'h0, 3'(SBC_INIT), 2'h0}, "resp");
    fault(1'b0);
    $display("test access finished");
    frame(16'h0182);
    chk(16'(watchdog_control_reg), 16'h0003, "wd parity");
    chk(16'(cmd_fault_flag), 16'h0001, "parity fault");
    frame(16'h2586);
    chk(16'({timer_on_time, timer_period}), 16'h0025, "timer");
    fault(1'b1);
    fault(1'b0);
    frame(16'h4486);
    chk(16'({timer_on_time, timer_period}), 16'h0025, "timer kept");
    fault(1'b1);
    foreach (stuck[i]) begin
      frame(stuck[i]);
      fault(1'b1);
    end
    frame(16'h0183);
    frame(16'h0083);
    chk(16'(aux_load_sharing), 16'h0001, "load share");
    fault(1'b1);
    frame(16'h8081);
    mode(SBC_NORMAL);
    fault(1'b1);
    $display("test faults finished");
    frame(16'h0582, 15);
    chk(16'({frame_err_flag, watchdog_control_reg}), 16'h0103, "short frame");
    frame(16'h0000, 0);
    chk(16'({resp[0], frame_err_flag}), 16'h0002, "err shown");
    frame(16'h0582, 16, 1'b1);
    chk(16'({frame_err_flag, watchdog_control_reg}), 16'h0103, "clk high");
    reset_output_pin = 1'b0;
    repeat (6) @(negedge ref_clk);
    frame(16'h0582);
    chk(resp, 16'hFFFF, "out in reset");
    reset_output_pin = 1'b1;
    chk(16'({frame_err_flag, watchdog_control_reg}), 16'h0103, "reset frame");
    frame(16'h0000, 0);
    $display("test frame_errors finished");
    wake_status_first_set = 8'h01;
    repeat (4) @(negedge ref_clk);
    wake_status_first_set = 8'h00;
    repeat (4) @(negedge ref_clk);
    frame(16'h8081);
    mode(SBC_STOP);
    chk(16'(n_int), 16'h0001, "int");
    fault(1'b0);
    frame(16'h3786);
    chk(16'({timer_on_time, timer_period}), 16'h0025, "stop timer");
    fault(1'b1);
    fault(1'b0);
    frame(16'h4081);
    mode(SBC_RESTART);
    leave_restart();
    fault(1'b1);
    frame(16'h8081);
    frame(16'h0581);
    mode(SBC_NORMAL);
    chk(16'(mode_settings), 16'h0000, "settings");
    fault(1'b1);
    frame(16'h4081);
    mode(SBC_RESTART);
    leave_restart();
    fault(1'b1);
    $display("test modes finished");
    wrap_up();
  end
  initial begin
    #400000;
    miscompares++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : sbc_spi_slave_checker_tb_top
